// >>> shared/mlevel_pkg.sv
// shared constants and types for the constellation encoder
package mlevel_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int CODE_W = 3;
    localparam int SYM_W = 4;
    localparam int SIZE_W = 2;
    localparam int PAIR_W = 2 * CODE_W;

    // ----------------------------------------------------------------
    // selector encodings
    // ----------------------------------------------------------------
    typedef enum logic [SIZE_W-1:0] {
        SIZE_4 = 2'b00,
        SIZE_8 = 2'b01,
        SIZE_16 = 2'b10
    } size_t;

    typedef enum logic {
        SHAPE_PHASE = 1'b0,
        SHAPE_AMPLITUDE = 1'b1
    } shape_t;

    typedef enum logic {
        MODE_FULL_ENCODE = 1'b0,
        MODE_SELFTEST_DISPLAY = 1'b1
    } mode_t;

    // ----------------------------------------------------------------
    // bits per symbol for each size
    // ----------------------------------------------------------------
    localparam logic [2:0] BITS_4 = 3'h2;
    localparam logic [2:0] BITS_8 = 3'h3;
    localparam logic [2:0] BITS_16 = 3'h4;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_RST = 3'h0;
    localparam logic [SYM_W-1:0] SYM_RST = 4'h0;
    localparam logic [2:0] BITCNT_RST = 3'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ = 20000000;
    localparam int BIT_CLK_MAX_HZ = 10000;
    localparam int BIT_PERIOD_MIN_CYC = SYS_CLK_HZ / BIT_CLK_MAX_HZ;

    // ----------------------------------------------------------------
    // buffering
    // ----------------------------------------------------------------
    localparam int BUF_DEPTH = 2;
    localparam int SYNC_STAGES = 2;

endpackage

// >>> testbench/bit_source.sv
// serial bit source driving the link pins
`timescale 1ns/100ps
`default_nettype none
module bit_source (
    // link pins
    output logic bit_clk,
    output logic serial_data
);
    initial begin
        bit_clk = 1'b0;
        serial_data = 1'b0;
    end
    // first bit sent is the top one of the n given
    task automatic send(input logic [63:0] bits, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            serial_data = bits[k];
            #100;
            bit_clk = 1'b1;
            #200;
            bit_clk = 1'b0;
            #100;
        end
        // released line shows the inverse; clock stands still between frames
        serial_data = ~bits[0];
    endtask
endmodule
`default_nettype wire

// >>> testbench/mlevel_encoder_properties.sv
// port assertions for the constellation encoder
`timescale 1ns/100ps
`default_nettype none
module mlevel_encoder_checker #(
    parameter int BUF_ENTRIES = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link and selectors
    input wire logic bit_clk,
    input wire logic serial_data,
    input wire logic mode_select_jumper,
    input wire logic shape_sel,
    input wire logic [mlevel_pkg::SIZE_W-1:0] size_sel,
    // codes and status
    input wire logic [mlevel_pkg::CODE_W-1:0] q_code,
    input wire logic [mlevel_pkg::CODE_W-1:0] i_code,
    input wire logic sym_valid,
    input wire logic dac_ready,
    input wire logic overrun,
    input wire logic selftest_active
);
    import mlevel_pkg::*;
    // ----------------------------------------------------------------
    // steadiness counters
    // ----------------------------------------------------------------
    logic [3:0] cfg_prev_reg;
    logic [7:0] ones_cnt_reg;
    logic [7:0] ones_cnt_next;
    logic [5:0] steady_cnt_reg;
    logic [5:0] steady_cnt_next;
    logic cfg_moved;
    assign cfg_moved = {mode_select_jumper, shape_sel, size_sel} != cfg_prev_reg;
    assign steady_cnt_next = (cfg_moved || !dac_ready) ? 6'h00 :
        (steady_cnt_reg == 6'h3f) ? steady_cnt_reg : steady_cnt_reg + 6'h01;
    assign ones_cnt_next = (cfg_moved || !dac_ready || !serial_data) ? 8'h00 :
        (ones_cnt_reg == 8'hff) ? ones_cnt_reg : ones_cnt_reg + 8'h01;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_prev_reg <= 4'h0;
            ones_cnt_reg <= 8'h00;
            steady_cnt_reg <= 6'h00;
        end else begin
            cfg_prev_reg <= {mode_select_jumper, shape_sel, size_sel};
            ones_cnt_reg <= ones_cnt_next;
            steady_cnt_reg <= steady_cnt_next;
        end
    end
    function automatic logic [3:0] levels(input logic [2:0] sel);
        case (sel)
            3'b001: return 4'h4;
            3'b010: return 4'h8;
            3'b100, 3'b111: return 4'h2;
            3'b101, 3'b110: return 4'h4;
            default: return 4'h3;
        endcase
    endfunction
    function automatic logic [PAIR_W-1:0] ones_pair(input logic [2:0] sel);
        case (sel)
            3'b001: return 6'h01;
            3'b010: return 6'h0a;
            3'b100, 3'b111: return 6'h09;
            3'b101, 3'b110: return 6'h12;
            default: return 6'h08;
        endcase
    endfunction
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    property p_reset_idle;
        $rose(arst_n) |-> !sym_valid && !overrun && q_code == CODE_RST && i_code == CODE_RST;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
    property p_mode_follow;
        $stable(mode_select_jumper) [*5] |-> selftest_active == mode_select_jumper;
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode flag off jumper");
    property p_hold_stall;
        sym_valid && !dac_ready |=> sym_valid && $stable(q_code) && $stable(i_code);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("pair lost in stall");
    property p_level_range;
        sym_valid && steady_cnt_reg == 6'h3f |-> {1'b0, q_code} < levels({shape_sel, size_sel})
            && {1'b0, i_code} < levels({shape_sel, size_sel});
    endproperty
    a_level_range: assert property (p_level_range) else $error("level out of range");
    property p_all_ones;
        sym_valid && !mode_select_jumper && ones_cnt_reg == 8'hff
            |-> {q_code, i_code} == ones_pair({shape_sel, size_sel});
    endproperty
    a_all_ones: assert property (p_all_ones) else $error("wrong all ones symbol");
    property p_ovr_cause;
        $rose(overrun) |-> !$past(dac_ready) && $past(sym_valid);
    endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without stall");
    property p_ovr_clear;
        $changed(shape_sel) || $changed(size_sel) |-> ##[1:6] !overrun;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept");
    property p_sym_after_clk;
        $rose(sym_valid) |-> $past(bit_clk, 3) || $past(bit_clk, 4) || $past(bit_clk, 5);
    endproperty
    a_sym_after_clk: assert property (p_sym_after_clk) else $error("symbol without clock");
    c_accept: cover property (sym_valid && dac_ready);
    c_overrun: cover property ($rose(overrun));
    c_selftest: cover property (selftest_active && sym_valid);
endmodule
bind mlevel_encoder mlevel_encoder_checker #(.BUF_ENTRIES(BUF_ENTRIES)) u_checker (
    .clk(clk), .arst_n(arst_n), .bit_clk(bit_clk), .serial_data(serial_data),
    .mode_select_jumper(mode_select_jumper), .shape_sel(shape_sel), .size_sel(size_sel),
    .q_code(q_code), .i_code(i_code), .sym_valid(sym_valid), .dac_ready(dac_ready),
    .overrun(overrun), .selftest_active(selftest_active));
`default_nettype wire

// >>> testbench/mlevel_encoder_tb_top.sv
// self-checking bench for the constellation encoder
`timescale 1ns/100ps
`default_nettype none
module mlevel_encoder_tb_top;
    import mlevel_pkg::*;
    logic clk;
    logic arst_n;
    logic bit_clk;
    logic serial_data;
    logic mode_select_jumper;
    logic shape_sel;
    logic [SIZE_W-1:0] size_sel;
    logic [CODE_W-1:0] q_code;
    logic [CODE_W-1:0] i_code;
    logic sym_valid;
    logic dac_ready;
    logic overrun;
    logic selftest_active;
    int errors;
    int compares;
    logic [PAIR_W-1:0] seen_q[$];
    // ----------------------------------------------------------------
    // clock, parts and capture
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    always #25 clk = ~clk;
    bit_source src (.bit_clk(bit_clk), .serial_data(serial_data));
    mlevel_encoder #(.BUF_ENTRIES(2)) DUT (
        .clk(clk), .arst_n(arst_n), .bit_clk(bit_clk), .serial_data(serial_data),
        .mode_select_jumper(mode_select_jumper), .shape_sel(shape_sel), .size_sel(size_sel),
        .q_code(q_code), .i_code(i_code), .sym_valid(sym_valid), .dac_ready(dac_ready),
        .overrun(overrun), .selftest_active(selftest_active));
    always @(posedge clk) begin
        if (arst_n === 1'b1 && sym_valid === 1'b1 && dac_ready === 1'b1)
            seen_q.push_back({q_code, i_code});
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test;
        $display("counts: compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [PAIR_W-1:0] exp,
                         input logic [PAIR_W-1:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_flag(input string what, input logic exp, input logic got);
        check(what, {5'h00, exp}, {5'h00, got});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic set_cfg(input logic md, input logic shp, input logic [1:0] sz);
        tick(1);
        mode_select_jumper = md;
        shape_sel = shp;
        size_sel = sz;
        tick(8);
        seen_q.delete();
    endtask
    task automatic wait_syms(input int n);
        int k;
        for (k = 0; k < 2000 && seen_q.size() < n; k++)
            tick(1);
        if (seen_q.size() < n) begin
            errors++;
            $display("CHECK FAILED symbol count expected %0d seen %0d", n, seen_q.size());
            finish_test;
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        check("reset pair", 6'h00, {q_code, i_code});
        check_flag("reset valid", 1'b0, sym_valid);
        check_flag("reset selftest", 1'b0, selftest_active);
        #5 arst_n = 1'b1;
        tick(6);
        $display("test reset done");
    endtask
    task automatic test_all_ones;
        logic [2:0] sel[7] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110};
        int nbits[7] = '{2, 3, 4, 2, 2, 3, 4};
        logic [PAIR_W-1:0] exp[7] = '{6'h08, 6'h01, 6'h0a, 6'h08, 6'h09, 6'h12, 6'h12};
        for (int k = 0; k < 7; k++) begin
            set_cfg(1'b0, sel[k][2], sel[k][1:0]);
            src.send('1, 10 * nbits[k]);
            wait_syms(10);
            foreach (seen_q[j]) check("all ones pair", exp[k], seen_q[j]);
        end
        $display("test all_ones done");
    endtask
    task automatic test_gray;
        set_cfg(1'b0, 1'b1, 2'b10);
        src.send(64'h6d, 8);
        wait_syms(2);
        check("qam16 first", 6'h0b, seen_q[0]);
        check("qam16 second", 6'h11, seen_q[1]);
        set_cfg(1'b0, 1'b1, 2'b01);
        src.send(64'h2a, 6);
        wait_syms(2);
        check("qam8 first", 6'h19, seen_q[0]);
        check("qam8 second", 6'h0b, seen_q[1]);
        $display("test gray done");
    endtask
    task automatic test_selftest;
        logic [PAIR_W-1:0] walk[4] = '{6'h00, 6'h01, 6'h09, 6'h08};
        set_cfg(1'b1, 1'b1, 2'b00);
        check_flag("selftest flag", 1'b1, selftest_active);
        src.send('1, 8);
        wait_syms(4);
        for (int k = 0; k < 4; k++) check("walk pair", walk[k], seen_q[k]);
        set_cfg(1'b0, 1'b1, 2'b00);
        check_flag("normal flag", 1'b0, selftest_active);
        $display("test selftest done");
    endtask
    task automatic test_overrun;
        set_cfg(1'b0, 1'b1, 2'b00);
        dac_ready = 1'b0;
        src.send(64'h1b, 8);
        tick(10);
        check_flag("overrun set", 1'b1, overrun);
        check_flag("valid held", 1'b1, sym_valid);
        check("held pair", 6'h00, {q_code, i_code});
        dac_ready = 1'b1;
        wait_syms(3);
        check("drain 0", 6'h00, seen_q[0]);
        check("drain 1", 6'h01, seen_q[1]);
        check("drain 2", 6'h08, seen_q[2]);
        check_flag("overrun sticky", 1'b1, overrun);
        set_cfg(1'b0, 1'b0, 2'b00);
        check_flag("overrun cleared", 1'b0, overrun);
        $display("test overrun done");
    endtask
    initial begin
        errors = 0;
        compares = 0;
        arst_n = 1'b0;
        mode_select_jumper = 1'b0;
        shape_sel = 1'b0;
        size_sel = 2'b00;
        dac_ready = 1'b1;
        repeat (6) @(posedge clk);
        test_reset;
        test_all_ones;
        test_gray;
        test_selftest;
        test_overrun;
        finish_test;
    end
endmodule
`default_nettype wire

// >>> verilog/mlevel_encoder.sv
// serial bit stream to quadrature/in-phase level code encoder
//
// Summary of operation
// - gather 2, 3 or 4 bits per symbol
// - two modes chosen by static jumper
// - normal mode encodes data with bit clock
// - self-test mode ignores data, uses clock only
// - shape and size pick one of six
// - phase sets use 3, 4, 8 levels
// - amplitude sets use 2, 4, 4 levels
// - symbols placed in Gray code order
// - steady high input in normal mode gives all-ones symbol
`timescale 1ns/100ps
`default_nettype none

module mlevel_encoder #(
    parameter int BUF_ENTRIES = mlevel_pkg::BUF_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link from the bit source
    input wire logic bit_clk,
    input wire logic serial_data,
    // board and panel selectors
    input wire logic mode_select_jumper,
    input wire logic shape_sel,
    input wire logic [mlevel_pkg::SIZE_W-1:0] size_sel,
    // level codes to the converters
    output logic [mlevel_pkg::CODE_W-1:0] q_code,
    output logic [mlevel_pkg::CODE_W-1:0] i_code,
    output logic sym_valid,
    input wire logic dac_ready,
    // status
    output logic overrun,
    output logic selftest_active
);
    import mlevel_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    localparam int PINS = 4 + SIZE_W;

    logic [PINS-1:0] pins_s;

    pin_sync #(
        .W(PINS)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in({bit_clk, serial_data, mode_select_jumper, shape_sel, size_sel}),
        .pin_sync_out(pins_s)
    );

    wire bclk_s = pins_s[PINS-1];
    wire data_s = pins_s[PINS-2];
    wire mode_s = pins_s[PINS-3];
    wire shape_s = pins_s[PINS-4];
    wire [SIZE_W-1:0] size_s = pins_s[SIZE_W-1:0];

    // ----------------------------------------------------------------
    // bit clock edge and configuration tracking
    // ----------------------------------------------------------------
    logic bclk_d_reg;
    logic mode_reg;
    logic shape_reg;
    logic [SIZE_W-1:0] size_reg;

    // data and clock share one synchroniser, so data stays aligned to the edge
    wire bclk_rise = bclk_s && !bclk_d_reg;
    wire cfg_change = (mode_s != mode_reg) || (shape_s != shape_reg) || (size_s != size_reg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bclk_d_reg <= 1'b0;
            mode_reg <= MODE_FULL_ENCODE;
            shape_reg <= SHAPE_PHASE;
            size_reg <= SIZE_4;
        end else begin
            bclk_d_reg <= bclk_s;
            mode_reg <= mode_s;
            shape_reg <= shape_s;
            size_reg <= size_s;
        end
    end

    wire is_selftest = (mode_reg == MODE_SELFTEST_DISPLAY);
    wire is_amp = (shape_reg == SHAPE_AMPLITUDE);

    // unused size code falls back to the four-point set
    wire sel_8 = (size_reg == SIZE_8);
    wire sel_16 = (size_reg == SIZE_16);
    wire [2:0] bits_per_sym = sel_16 ? BITS_16 : (sel_8 ? BITS_8 : BITS_4);

    // ----------------------------------------------------------------
    // bit grouping
    // ----------------------------------------------------------------
    logic [SYM_W-1:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [SYM_W-1:0] selftest_display_mode_cnt_reg;

    wire last_bit = (bit_cnt_reg == bits_per_sym - 3'h1);
    wire group_done = bclk_rise && last_bit;

    // first received bit ends up as the most significant bit of the symbol
    wire [SYM_W-1:0] shift_next = {shift_reg[SYM_W-2:0], data_s};
    wire [SYM_W-1:0] len_mask = sel_16 ? 4'hf : (sel_8 ? 4'h7 : 4'h3);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= SYM_RST;
            bit_cnt_reg <= BITCNT_RST;
        end else if (cfg_change) begin
            shift_reg <= SYM_RST;
            bit_cnt_reg <= BITCNT_RST;
        end else if (bclk_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= last_bit ? BITCNT_RST : bit_cnt_reg + 3'h1;
        end
    end

    // self-test counter advances one symbol per bit group
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            selftest_display_mode_cnt_reg <= SYM_RST;
        end else if (cfg_change) begin
            selftest_display_mode_cnt_reg <= SYM_RST;
        end else if (group_done && is_selftest) begin
            selftest_display_mode_cnt_reg <= (selftest_display_mode_cnt_reg + 4'h1) & len_mask;
        end
    end

    // counter is Gray coded so the display walks neighbouring points
    wire [SYM_W-1:0] selftest_display_mode_bits = selftest_display_mode_cnt_reg ^ {1'b0, selftest_display_mode_cnt_reg[SYM_W-1:1]};
    wire [SYM_W-1:0] data_bits = shift_next & len_mask;
    // serial data is not looked at in self-test
    wire [SYM_W-1:0] sym_bits = is_selftest ? selftest_display_mode_bits : data_bits;

    // ----------------------------------------------------------------
    // symbol to level mapping
    // ----------------------------------------------------------------
    function automatic logic [SYM_W-1:0] gray_to_bin(input logic [SYM_W-1:0] g);
        logic [SYM_W-1:0] b;
        b = '0;
        b[SYM_W-1] = g[SYM_W-1];
        for (int n = SYM_W - 2; n >= 0; n--) begin
            b[n] = b[n+1] ^ g[n];
        end
        return b;
    endfunction

    // cosine-like level index around a circle of 2*half points
    function automatic logic [CODE_W-1:0] fold(input logic [SYM_W-1:0] k,
                                               input logic [SYM_W-1:0] half);
        logic [SYM_W-1:0] v;
        v = (k < half) ? (half - 4'h1 - k) : (k - half);
        return v[CODE_W-1:0];
    endfunction

    // three-level axis for the four-point circle: +, 0, -, 0
    function automatic logic [CODE_W-1:0] axis3(input logic [1:0] k);
        logic [CODE_W-1:0] v;
        v = 3'h1;
        if (k == 2'h0) begin
            v = 3'h2;
        end else if (k == 2'h2) begin
            v = 3'h0;
        end
        return v;
    endfunction

    // zero-padded Gray code decodes the same as the short word
    wire [SYM_W-1:0] pos = gray_to_bin(sym_bits);
    wire [1:0] pos4 = pos[1:0];
    wire [SYM_W-1:0] pos8 = pos & 4'h7;

    // phase sets: 3, 4 and 8 levels per branch
    wire [CODE_W-1:0] p4_i = axis3(pos4);
    wire [CODE_W-1:0] p4_q = axis3(pos4 - 2'h1);
    wire [CODE_W-1:0] p8_i = fold(pos8, 4'h4);
    wire [CODE_W-1:0] p8_q = fold((pos8 - 4'h2) & 4'h7, 4'h4);
    wire [CODE_W-1:0] p16_i = fold(pos, 4'h8);
    wire [CODE_W-1:0] p16_q = fold(pos - 4'h4, 4'h8);

    // amplitude sets: 2, 4 and 4 levels per branch, Gray on each axis
    wire [SYM_W-1:0] low_bin = gray_to_bin({2'b00, sym_bits[1:0]});
    wire [SYM_W-1:0] high_bin = gray_to_bin({2'b00, sym_bits[3:2]});
    wire [CODE_W-1:0] a4_i = {2'b00, sym_bits[0]};
    wire [CODE_W-1:0] a4_q = {2'b00, sym_bits[1]};
    wire [CODE_W-1:0] a8_i = low_bin[CODE_W-1:0];
    wire [CODE_W-1:0] a8_q = {1'b0, sym_bits[2], low_bin[0]};
    wire [CODE_W-1:0] a16_i = low_bin[CODE_W-1:0];
    wire [CODE_W-1:0] a16_q = high_bin[CODE_W-1:0];

    // in normal mode an all-ones group lands on one fixed point per set
    wire [CODE_W-1:0] phase_i = sel_16 ? p16_i : (sel_8 ? p8_i : p4_i);
    wire [CODE_W-1:0] phase_q = sel_16 ? p16_q : (sel_8 ? p8_q : p4_q);
    wire [CODE_W-1:0] amp_i = sel_16 ? a16_i : (sel_8 ? a8_i : a4_i);
    wire [CODE_W-1:0] amp_q = sel_16 ? a16_q : (sel_8 ? a8_q : a4_q);
    wire [CODE_W-1:0] map_i = is_amp ? amp_i : phase_i;
    wire [CODE_W-1:0] map_q = is_amp ? amp_q : phase_q;

    // ----------------------------------------------------------------
    // symbol buffer
    // ----------------------------------------------------------------
    logic buf_in_ready;
    logic buf_out_valid;
    logic [PAIR_W-1:0] buf_out_data;

    wire push_sym = group_done && !cfg_change;
    logic sym_valid_reg;

    wire out_free = !sym_valid_reg || dac_ready;

    sym_buffer #(
        .W(PAIR_W),
        .DEPTH(BUF_ENTRIES)
    ) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push_sym),
        .in_ready(buf_in_ready),
        .in_data({map_q, map_i}),
        .out_valid(buf_out_valid),
        .out_ready(out_free),
        .out_data(buf_out_data)
    );

    // ----------------------------------------------------------------
    // output stage
    // ----------------------------------------------------------------
    logic [CODE_W-1:0] q_code_reg;
    logic [CODE_W-1:0] i_code_reg;
    logic overrun_reg;
    logic selftest_reg;

    wire load_out = buf_out_valid && out_free;
    // the bit source cannot be held, so a full buffer drops the symbol
    wire overrun_set = push_sym && !buf_in_ready;

    // level codes hold their last value between symbols, as on a converter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_code_reg <= CODE_RST;
            i_code_reg <= CODE_RST;
            sym_valid_reg <= 1'b0;
        end else begin
            if (load_out) begin
                q_code_reg <= buf_out_data[PAIR_W-1:CODE_W];
                i_code_reg <= buf_out_data[CODE_W-1:0];
            end
            if (load_out) begin
                sym_valid_reg <= 1'b1;
            end else if (dac_ready) begin
                sym_valid_reg <= 1'b0;
            end
        end
    end

    // overrun is sticky until the selectors change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun_reg <= 1'b0;
            selftest_reg <= 1'b0;
        end else begin
            if (overrun_set) begin
                overrun_reg <= 1'b1;
            end else if (cfg_change) begin
                overrun_reg <= 1'b0;
            end
            selftest_reg <= is_selftest;
        end
    end

    assign q_code = q_code_reg;
    assign i_code = i_code_reg;
    assign sym_valid = sym_valid_reg;
    assign overrun = overrun_reg;
    assign selftest_active = selftest_reg;

endmodule
`default_nettype wire

// >>> verilog/pin_sync.sv
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pins and synchronised copies
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync_out
);
    import mlevel_pkg::*;

    logic [W-1:0] meta_reg;
    logic [W-1:0] stable_reg;

    // ----------------------------------------------------------------
    // first stage feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            stable_reg <= meta_reg;
        end
    end

    assign pin_sync_out = stable_reg;

endmodule
`default_nettype wire

// >>> verilog/sym_buffer.sv
// small valid/ready buffer held in flip-flops
`timescale 1ns/100ps
`default_nettype none

module sym_buffer #(
    parameter int W = 6,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import mlevel_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
    wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;

    assign in_ready = (count_reg != CNT_FULL);
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int n = 0; n < DEPTH; n++) begin
                mem_reg[n] <= '0;
            end
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // ----------------------------------------------------------------
    // pointers and fill level
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_next;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_next;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire
